// ===== hdl/sdram_burst_col.v
// column address of one burst beat
`timescale 1ns/1ps
`include "sdram_defines.vh"
module sdram_burst_col (
   input wire [`COL_W-1:0] start_i,
   input wire [`COL_W-1:0] beat_i,
   input wire [9:0] len_i,
   input wire interleave_i,
   output wire [`COL_W-1:0] col_o
);
   // block mask; full page gives all ones, so it wraps over the row
   wire [`COL_W-1:0] blk_mask;
   wire [`COL_W-1:0] seq_col;
   wire [`COL_W-1:0] int_col;

   assign blk_mask = len_i[`COL_W-1:0] - 9'h001;
   assign seq_col = start_i + beat_i;
   assign int_col = start_i ^ beat_i;
   assign col_o = (start_i & ~blk_mask) | ((interleave_i ? int_col : seq_col) & blk_mask);
endmodule // sdram_burst_col

// ===== hdl/sdram_defines.vh
// constants for the synchronous dram device model
// Overview of operation
// - mode bits 6..4 pick latency two/three
// - mode bit 3 picks sequential or interleaved
// - burst length code, full page 512 columns when sequential, one word when interleaved
// - burst wraps inside aligned block
// - mode bit 9 picks burst or single write
// - drivers on one cycle before first word
// - outputs float clock after last word
// - write data taken with write command
// - read autoprecharge closes bank after burst
// - write autoprecharge closes bank after burst
// - read burst stop floats after latency
// - write burst stop stores nothing onward
// - new read cuts old read burst
// - new write cuts old write burst
// - byte masks: read latency two, write zero
`ifndef SDRAM_DEFINES_VH
`define SDRAM_DEFINES_VH

// command codes as {row strobe, column strobe, write enable}, low active
`define CMD_MODE_LOAD 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ROW_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_BURST_TERMINATE 3'h6
`define CMD_NOP 3'h7

// operating_mode_setting fields
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define MODE_WBL_BIT 9
`define MODE_RESET 12'h020
`define MODE_BANK_SEL 2'h0

`define CL_TWO 3'h2
`define CL_THREE 3'h3

`define BL_ONE 3'h0
`define BL_TWO 3'h1
`define BL_FOUR 3'h2
`define BL_EIGHT 3'h3
`define BL_FULL 3'h7
`define LEN_ONE 10'h001
`define LEN_TWO 10'h002
`define LEN_FOUR 10'h004
`define LEN_EIGHT 10'h008
`define LEN_FULL 10'h200

`define AUTOPRECHARGE_BIT 10

`define DATA_W 16
`define ADDR_W 12
`define ROW_W 12
`define COL_W 9
`define BANK_W 2
`define FIFO_DEPTH 32

`endif

// ===== hdl/sdram_device.v
// four-bank 16-bit single-data-rate synchronous dram device
`timescale 1ns/1ps
`include "sdram_defines.vh"
module sdram_device #(
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire CLK_I,
   input wire RST_I,
   input wire CKE_I,
   input wire CS_N_I,
   input wire RAS_N_I,
   input wire CAS_N_I,
   input wire WE_N_I,
   input wire [`BANK_W-1:0] BA_I,
   input wire [`ADDR_W-1:0] ADDR_I,
   input wire UPPER_BYTE_MASK_I,
   input wire LOWER_BYTE_MASK_I,
   input wire [`DATA_W-1:0] DQ_I,
   output wire [`DATA_W-1:0] DQ_O,
   output wire [1:0] DQ_OE_O
);
   localparam MEM_AW = `BANK_W + `ROW_W + `COL_W;

   // burst length from mode, single write forces one word
   function [9:0] burst_len;
      input [`ADDR_W-1:0] mode;
      input is_write;
      begin
         case (mode[`MODE_BL_MSB:`MODE_BL_LSB])
            `BL_ONE: burst_len = `LEN_ONE;
            `BL_TWO: burst_len = `LEN_TWO;
            `BL_FOUR: burst_len = `LEN_FOUR;
            `BL_EIGHT: burst_len = `LEN_EIGHT;
            `BL_FULL: burst_len = mode[`MODE_BT_BIT] ? `LEN_ONE : `LEN_FULL;
            default: burst_len = `LEN_ONE;
         endcase
         if (is_write & mode[`MODE_WBL_BIT]) begin
            burst_len = `LEN_ONE;
         end
      end
   endfunction

   reg [`DATA_W-1:0] mem [0:(1 << MEM_AW)-1];
   reg [`ADDR_W-1:0] mode_r;
   reg [`ROW_W-1:0] row_r [0:3];
   reg [3:0] open_r;
   reg burst_act_r;
   reg burst_wr_r;
   reg burst_ap_r;
   reg [`BANK_W-1:0] burst_bank_r;
   reg [`COL_W-1:0] burst_start_r;
   reg [`COL_W-1:0] beat_r;
   reg [9:0] burst_len_r;
   reg fetch_d1_r;
   reg fetch_d2_r;
   reg upper_mask_d_r;
   reg lower_mask_d_r;
   reg [`DATA_W-1:0] dq_r;
   reg oe_hi_r;
   reg oe_lo_r;
   integer i;

   wire cmd_en;
   wire [2:0] cmd;
   wire is_rd;
   wire is_wr;
   wire is_act;
   wire is_pre;
   wire is_precharge_all_command;
   wire is_bst;
   wire is_mode;
   wire start_new;
   wire kill;
   wire cont;
   wire acc_valid;
   wire acc_wr;
   wire acc_ap;
   wire [`BANK_W-1:0] acc_bank;
   wire [`COL_W-1:0] acc_start;
   wire [`COL_W-1:0] acc_beat;
   wire [9:0] acc_len;
   wire [`COL_W-1:0] acc_col;
   wire [MEM_AW-1:0] acc_addr;
   wire [9:0] beat_nxt;
   wire last;
   wire rd_fetch;
   wire fifo_in_ready;
   wire stall;
   wire push;
   wire advance;
   wire wr_store;
   wire lat_three;
   wire pop;
   wire pre_drive;
   wire fifo_out_valid;
   wire [`DATA_W-1:0] fifo_out_data;

   assign cmd_en = CKE_I & ~CS_N_I;
   assign cmd = {RAS_N_I, CAS_N_I, WE_N_I};
   assign is_rd = cmd_en & (cmd == `CMD_READ) & open_r[BA_I];
   assign is_wr = cmd_en & (cmd == `CMD_WRITE) & open_r[BA_I];
   assign is_act = cmd_en & (cmd == `CMD_ROW_ACTIVATE);
   assign is_pre = cmd_en & (cmd == `CMD_PRECHARGE);
   assign is_precharge_all_command = is_pre & ADDR_I[`AUTOPRECHARGE_BIT];
   assign is_bst = cmd_en & (cmd == `CMD_BURST_TERMINATE);
   assign is_mode = cmd_en & (cmd == `CMD_MODE_LOAD) & (BA_I == `MODE_BANK_SEL);

   // a new column command, a stop or a precharge of the bank ends the burst
   assign start_new = is_rd | is_wr;
   assign kill = start_new | is_bst | is_precharge_all_command | (is_pre & (BA_I == burst_bank_r));
   assign cont = burst_act_r & ~kill;
   assign acc_valid = start_new | cont;
   assign acc_wr = start_new ? is_wr : burst_wr_r;
   assign acc_ap = start_new ? ADDR_I[`AUTOPRECHARGE_BIT] : burst_ap_r;
   assign acc_bank = start_new ? BA_I : burst_bank_r;
   assign acc_start = start_new ? ADDR_I[`COL_W-1:0] : burst_start_r;
   assign acc_beat = start_new ? {`COL_W{1'b0}} : beat_r;
   assign acc_len = start_new ? burst_len(mode_r, is_wr) : burst_len_r;

   sdram_burst_col u_col (
      .start_i(acc_start),
      .beat_i(acc_beat),
      .len_i(acc_len),
      .interleave_i(mode_r[`MODE_BT_BIT]),
      .col_o(acc_col)
   );

   assign acc_addr = {acc_bank, row_r[acc_bank], acc_col};
   assign beat_nxt = {1'b0, acc_beat} + 10'h001;
   // full page never ends by itself, it wraps until stopped
   assign last = (acc_len != `LEN_FULL) & (beat_nxt == acc_len);
   assign rd_fetch = acc_valid & ~acc_wr;
   assign stall = rd_fetch & ~fifo_in_ready;
   assign push = rd_fetch & fifo_in_ready;
   assign advance = acc_valid & ~stall;
   assign wr_store = acc_valid & acc_wr;

   assign lat_three = (mode_r[`MODE_CL_MSB:`MODE_CL_LSB] == `CL_THREE);
   assign pop = lat_three ? fetch_d2_r : fetch_d1_r;
   assign pre_drive = lat_three ? fetch_d1_r : push;

   // read words wait here until their latency slot comes up
   sdram_fifo #(
      .WIDTH(`DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .in_valid_i(rd_fetch),
      .in_ready_o(fifo_in_ready),
      .in_data_i(mem[acc_addr]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_out_data)
   );

   // write beats, byte masks act in the same clock
   always @(posedge CLK_I) begin
      if (wr_store) begin
         if (~UPPER_BYTE_MASK_I) begin
            mem[acc_addr][15:8] <= DQ_I[15:8];
         end
         if (~LOWER_BYTE_MASK_I) begin
            mem[acc_addr][7:0] <= DQ_I[7:0];
         end
      end
   end

   // mode register and bank rows
   always @(posedge CLK_I) begin
      if (RST_I) begin
         mode_r <= `MODE_RESET;
         open_r <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            row_r[i] <= {`ROW_W{1'b0}};
         end
      end else begin
         if (is_mode) begin
            mode_r <= ADDR_I;
         end
         if (is_precharge_all_command) begin
            open_r <= 4'h0;
         end else if (is_pre) begin
            open_r[BA_I] <= 1'b0;
         end
         if (burst_act_r & burst_ap_r & kill) begin
            open_r[burst_bank_r] <= 1'b0;
         end
         if (advance & last & acc_ap) begin
            open_r[acc_bank] <= 1'b0;
         end
         if (is_act) begin
            open_r[BA_I] <= 1'b1;
            row_r[BA_I] <= ADDR_I;
         end
      end
   end

   // burst sequencer shared by reads and writes
   always @(posedge CLK_I) begin
      if (RST_I) begin
         burst_act_r <= 1'b0;
         burst_wr_r <= 1'b0;
         burst_ap_r <= 1'b0;
         burst_bank_r <= {`BANK_W{1'b0}};
         burst_start_r <= {`COL_W{1'b0}};
         beat_r <= {`COL_W{1'b0}};
         burst_len_r <= `LEN_ONE;
      end else if (acc_valid) begin
         burst_act_r <= ~(advance & last);
         burst_wr_r <= acc_wr;
         burst_ap_r <= acc_ap;
         burst_bank_r <= acc_bank;
         burst_start_r <= acc_start;
         burst_len_r <= acc_len;
         beat_r <= advance ? beat_nxt[`COL_W-1:0] : acc_beat;
      end else if (burst_act_r) begin
         burst_act_r <= 1'b0;
      end
   end

   // output stage: data registered one edge before it is sampled
   always @(posedge CLK_I) begin
      if (RST_I) begin
         fetch_d1_r <= 1'b0;
         fetch_d2_r <= 1'b0;
         upper_mask_d_r <= 1'b0;
         lower_mask_d_r <= 1'b0;
         dq_r <= 16'h0000;
         oe_hi_r <= 1'b0;
         oe_lo_r <= 1'b0;
      end else begin
         fetch_d1_r <= push;
         fetch_d2_r <= fetch_d1_r;
         upper_mask_d_r <= UPPER_BYTE_MASK_I;
         lower_mask_d_r <= LOWER_BYTE_MASK_I;
         if (pop & fifo_out_valid) begin
            dq_r <= fifo_out_data;
         end
         oe_hi_r <= (pop | pre_drive) & ~upper_mask_d_r;
         oe_lo_r <= (pop | pre_drive) & ~lower_mask_d_r;
      end
   end

   assign DQ_O = dq_r;
   assign DQ_OE_O = {oe_hi_r, oe_lo_r};
endmodule // sdram_device

// ===== hdl/sdram_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdram_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32
) (
   input wire clk_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   localparam AW = $clog2(DEPTH);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;

   assign in_ready_o = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr_r];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // sdram_fifo

// ===== tb/sdram_ctrl_model.sv
// memory controller model driving the dram pins
`timescale 1ns/1ps
module sdram_ctrl_model #(
   parameter INIT_CYCLES = 10000,
   parameter ACTIVATE_TO_COLUMN_DELAY = 2,
   parameter PRECHARGE_PERIOD = 2,
   parameter TRC = 4
) (
   input wire clk_i,
   output reg cke_o,
   output reg cs_n_o,
   output reg [2:0] cmd_o,
   output reg [1:0] ba_o,
   output reg [11:0] addr_o,
   output reg [1:0] mask_o,
   output reg [15:0] dq_o
);
   initial begin
      cke_o = 1'b1;
      cs_n_o = 1'b0;
      cmd_o = 3'h7;
      ba_o = 2'h0;
      addr_o = 12'h000;
      mask_o = 2'h0;
      dq_o = 16'h0000;
   end
   task cmd(input [2:0] c, input [1:0] b, input [11:0] a, input [15:0] d, input [1:0] m);
      begin
         @(posedge clk_i);
         #1;
         cke_o = 1'b1;
         cs_n_o = 1'b0;
         cmd_o = c;
         ba_o = b;
         addr_o = a;
         mask_o = m;
         dq_o = d;
      end
   endtask
   // command with clock enable and chip select under test control
   task gated(input ck, input csn, input [2:0] c, input [11:0] a);
      begin
         @(posedge clk_i);
         #1;
         cke_o = ck;
         cs_n_o = csn;
         cmd_o = c;
         ba_o = 2'h1;
         addr_o = a;
         mask_o = 2'h0;
      end
   endtask
   // idle data lines toggle instead of holding
   task nop(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
            cmd(3'h7, 2'h0, 12'h000, ~dq_o, 2'h0);
      end
   endtask
   task setmode(input [11:0] m);
      begin
         cmd(3'h2, 2'h0, 12'h400, 16'h0000, 2'h0);
         nop(PRECHARGE_PERIOD);
         cmd(3'h0, 2'h0, m & 12'h27f, 16'h0000, 2'h0);
         nop(2);
         cmd(3'h3, 2'h1, 12'h005, 16'h0000, 2'h0);
         nop(ACTIVATE_TO_COLUMN_DELAY);
      end
   endtask
   task init(input [11:0] m);
      begin
         nop(INIT_CYCLES);
         cmd(3'h2, 2'h0, 12'h400, 16'h0000, 2'h0);
         nop(PRECHARGE_PERIOD);
         repeat (8) begin
            cmd(3'h1, 2'h0, 12'h000, 16'h0000, 2'h0);
            nop(TRC);
         end
         setmode(m);
      end
   endtask
endmodule // sdram_ctrl_model

// ===== tb/sdram_device_bench.sv
// self-checking bench for the dram device
`timescale 1ns/1ps
`include "sdram_defines.vh"
module sdram_device_bench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   wire cke;
   wire cs_n;
   wire [2:0] c;
   wire [1:0] ba;
   wire [1:0] m;
   wire [11:0] addr;
   wire [15:0] dq;
   wire [15:0] rdq;
   wire [1:0] oe;
   integer fail_count = 0;
   integer n_compared = 0;
   integer cycles = 0;
   always #10 clk = ~clk;
   sdram_ctrl_model u_ctl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(c), .ba_o(ba),
      .addr_o(addr), .mask_o(m), .dq_o(dq));
   sdram_device u_dut (.CLK_I(clk), .RST_I(rst), .CKE_I(cke), .CS_N_I(cs_n),
      .RAS_N_I(c[2]), .CAS_N_I(c[1]), .WE_N_I(c[0]), .BA_I(ba), .ADDR_I(addr),
      .UPPER_BYTE_MASK_I(m[1]), .LOWER_BYTE_MASK_I(m[0]), .DQ_I(dq), .DQ_O(rdq),
      .DQ_OE_O(oe));
   task print_verdict;
      begin
         $display("compared %0d mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task check16(input [47:0] name, input [15:0] exp, input [15:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wr4(input [8:0] col, input [63:0] w, input [1:0] m0);
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            u_ctl.cmd(k == 0 ? `CMD_WRITE : `CMD_NOP, 2'h1, {3'h0, col}, w[63-16*k -: 16],
               k == 0 ? m0 : 2'h0);
         u_ctl.nop(2);
      end
   endtask
   task rd4(input [8:0] col, input integer lat, input [63:0] exp);
      integer k;
      begin
         u_ctl.cmd(`CMD_READ, 2'h1, {3'h0, col}, 16'h5555, 2'h0);
         u_ctl.nop(lat);
         for (k = 0; k < 4; k = k + 1) begin
            check16("rdata", exp[63-16*k -: 16], rdq);
            check16("drive", 16'h0003, {14'h0, oe});
            u_ctl.nop(1);
         end
         check16("float", 16'h0000, {14'h0, oe});
      end
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      check16("rstdrv", 16'h0000, {14'h0, oe});
      u_ctl.init(12'h022);
      wr4(9'h005, 64'h1111_2222_3333_4444, 2'h0);
      rd4(9'h004, 2, 64'h4444_1111_2222_3333);
      u_ctl.setmode(12'h02a);
      rd4(9'h006, 2, 64'h2222_3333_4444_1111);
      u_ctl.setmode(12'h032);
      rd4(9'h004, 3, 64'h4444_1111_2222_3333);
      u_ctl.setmode(12'h222);
      wr4(9'h004, 64'h5a5a_0000_0000_0000, 2'h1);
      rd4(9'h004, 2, 64'h5a44_1111_2222_3333);
      u_ctl.cmd(`CMD_READ, 2'h1, 12'h004, 16'h5555, 2'h0);
      u_ctl.cmd(`CMD_READ, 2'h1, 12'h006, 16'haaaa, 2'h0);
      u_ctl.nop(1);
      check16("cut0", 16'h5a44, rdq);
      u_ctl.cmd(`CMD_BURST_TERMINATE, 2'h0, 12'h000, 16'h5555, 2'h0);
      check16("cut1", 16'h2222, rdq);
      u_ctl.nop(1);
      check16("cut2", 16'h3333, rdq);
      u_ctl.nop(1);
      check16("stop", 16'h0000, {14'h0, oe});
      u_ctl.nop(2);
      u_ctl.cmd(`CMD_READ, 2'h1, 12'h004, 16'h0000, 2'h2);
      u_ctl.nop(2);
      check16("umask", 16'h0001, {14'h0, oe});
      check16("udata", 16'h5a44, rdq);
      u_ctl.nop(6);
      u_ctl.gated(1'b0, 1'b0, `CMD_READ, 12'h004);
      u_ctl.gated(1'b1, 1'b1, `CMD_READ, 12'h004);
      u_ctl.nop(3);
      check16("ignored", 16'h0000, {14'h0, oe});
      u_ctl.nop(2);
      print_verdict;
   end
endmodule // sdram_device_bench

// ===== tb/sdram_device_properties.sv
// read drive timing checker for the dram device
`timescale 1ns/1ps
module sdram_device_properties (
   input wire CLK_I,
   input wire RST_I,
   input wire CKE_I,
   input wire CS_N_I,
   input wire RAS_N_I,
   input wire CAS_N_I,
   input wire WE_N_I,
   input wire [1:0] BA_I,
   input wire [11:0] ADDR_I,
   input wire UPPER_BYTE_MASK_I,
   input wire LOWER_BYTE_MASK_I,
   input wire [1:0] DQ_OE_O
);
   wire [2:0] cmd = (CKE_I && !CS_N_I) ? {RAS_N_I, CAS_N_I, WE_N_I} : 3'h7;
   wire rd = cmd == 3'h5;
   wire burst_terminate_command = cmd == 3'h6;
   reg [6:0] mode_r;
   always @(posedge CLK_I) begin
      if (RST_I)
         mode_r <= 7'h20;
      else if (cmd == 3'h0 && BA_I == 2'h0)
         mode_r <= ADDR_I[6:0];
   end
   wire lat3 = mode_r[6:4] == 3'h3;
   wire bl4 = mode_r[2:0] == 3'h2;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   property p_oe_reset;
      disable iff (1'b0) RST_I |=> DQ_OE_O == 2'h0;
   endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("drive on after reset");
   property p_oe_rise;
      $rose(|DQ_OE_O) |-> (lat3 ? $past(rd, 2) : $past(rd, 1));
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("drive start off latency");
   property p_bl4_l2;
      (rd && bl4 && !lat3) ##1 (!rd)[*5] |=> DQ_OE_O == 2'h0;
   endproperty
   a_bl4_l2: assert property (p_bl4_l2) else $error("drive not released");
   property p_bl4_l3;
      (rd && bl4 && lat3) ##1 (!rd)[*6] |=> DQ_OE_O == 2'h0;
   endproperty
   a_bl4_l3: assert property (p_bl4_l3) else $error("drive not released");
   property p_bst;
      (burst_terminate_command && !lat3) ##1 !rd |=> DQ_OE_O == 2'h0;
   endproperty
   a_bst: assert property (p_bst) else $error("drive after burst stop");
   property p_mask_lo;
      $past(LOWER_BYTE_MASK_I, 2) |-> !DQ_OE_O[0];
   endproperty
   a_mask_lo: assert property (p_mask_lo) else $error("lower byte driven");
   property p_mask_hi;
      $past(UPPER_BYTE_MASK_I, 2) |-> !DQ_OE_O[1];
   endproperty
   a_mask_hi: assert property (p_mask_hi) else $error("upper byte driven");
   property p_pair;
      DQ_OE_O[1] != DQ_OE_O[0] |-> $past(UPPER_BYTE_MASK_I != LOWER_BYTE_MASK_I, 2);
   endproperty
   a_pair: assert property (p_pair) else $error("byte drives split");
   c_rd3: cover property (rd && lat3);
   c_bst: cover property (burst_terminate_command);
   c_cut: cover property (rd ##1 rd);
endmodule // sdram_device_properties
bind sdram_device sdram_device_properties u_props (.CLK_I(CLK_I), .RST_I(RST_I),
   .CKE_I(CKE_I), .CS_N_I(CS_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I),
   .WE_N_I(WE_N_I), .BA_I(BA_I), .ADDR_I(ADDR_I), .UPPER_BYTE_MASK_I(UPPER_BYTE_MASK_I),
   .LOWER_BYTE_MASK_I(LOWER_BYTE_MASK_I), .DQ_OE_O(DQ_OE_O));
